// ### rtl/osm_pkg.sv
`default_nettype none
package osm_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int MSB    = 7;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic       DEST_W  = 1'b0;
    localparam logic       DEST_F  = 1'b1;
    typedef enum logic [1:0] {
        OSM_OP_IOR,
        OSM_OP_LSL,
        OSM_OP_MOV,
        OSM_OP_NONE
    } osm_op_e;
endpackage
`default_nettype wire

// ### rtl/osm_file_mem.sv
`timescale 1ns/100ps
`default_nettype none
module osm_file_mem #(
    parameter int DW = 8,
    parameter int AW = 7
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output var  logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write, then registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule // osm_file_mem
`default_nettype wire

// ### rtl/osm_core.sv
// Contract
// RULE1 - OR of working and file register; only zero flag changes.
// RULE2 - Destination bit 0 writes working register, 1 writes file register.
// RULE3 - Left shift: file bit 7 to carry, bits 6:0 to result 7:1.
// RULE4 - Left shift: result bit 0 is zero; carry and zero updated.
// RULE5 - Move file passes file contents unchanged to chosen destination.
// RULE6 - Move file updates zero flag even when written back to itself.
// RULE7 - Zero flag set when result zero; each instruction one cycle.
`timescale 1ns/100ps
`default_nettype none
module osm_core #(
    parameter int AW = osm_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // File register preload
    input  wire logic                       load_en,
    input  wire logic [AW-1:0]              load_addr,
    input  wire logic [osm_pkg::DATA_W-1:0] load_data,
    // Instruction
    input  wire logic                       op_valid,
    input  wire osm_pkg::osm_op_e           op,
    input  wire logic [AW-1:0]              op_addr,
    input  wire logic                       op_dest,
    // Results
    output var  logic [osm_pkg::DATA_W-1:0] w_q,
    output var  logic                       zero_q,
    output var  logic                       carry_q,
    output var  logic                       done_q
);
    typedef enum logic {OSM_IDLE, OSM_EXEC} osm_state_e;

    osm_state_e                 state_q;
    osm_pkg::osm_op_e           op_q;
    logic [AW-1:0]              addr_q;
    logic                       dest_q;
    logic [osm_pkg::DATA_W-1:0] fdata;
    logic [osm_pkg::DATA_W-1:0] res;
    logic                       we;
    logic [AW-1:0]              waddr;
    logic [osm_pkg::DATA_W-1:0] wdata;

    // Instruction accepted at this edge
    function automatic logic starts_op(
        input logic             valid,
        input osm_pkg::osm_op_e code
    );
        return valid && (code != osm_pkg::OSM_OP_NONE);
    endfunction

    // Execute stage holds the given operation
    function automatic logic exec_is(
        input osm_state_e       st,
        input osm_pkg::osm_op_e code,
        input osm_pkg::osm_op_e want
    );
        return (st == OSM_EXEC) && (code == want);
    endfunction

    // Operand fetch on acceptance, execute next edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= OSM_IDLE;
            op_q    <= osm_pkg::OSM_OP_NONE;
            addr_q  <= '0;
            dest_q  <= 1'b0;
        end else begin
            state_q <= starts_op(op_valid, op) ? OSM_EXEC : OSM_IDLE;
            op_q    <= op;
            addr_q  <= op_addr;
            dest_q  <= op_dest;
        end
    end

    // File register array, read registered on acceptance
    osm_file_mem #(
        .DW (osm_pkg::DATA_W),
        .AW (AW)
    ) osm_file_mem_inst (
        .clk   (clk),
        .we    (we),
        .waddr (waddr),
        .wdata (wdata),
        .raddr (op_addr),
        .rdata (fdata)
    );

    always_comb begin
        unique case (op_q)
            // RULE1 OR datapath
            osm_pkg::OSM_OP_IOR: res = w_q | fdata;
            // RULE3 RULE4 shift datapath
            osm_pkg::OSM_OP_LSL: res = {fdata[osm_pkg::MSB-1:0], 1'b0};
            // RULE5 pass through
            osm_pkg::OSM_OP_MOV: res = fdata;
            // Idle code, result unused
            osm_pkg::OSM_OP_NONE: res = fdata;
        endcase
    end

    // RULE2 file write-back
    always_comb begin
        if (state_q == OSM_EXEC && dest_q == osm_pkg::DEST_F) begin
            we    = 1'b1;
            waddr = addr_q;
            wdata = res;
        end else begin
            we    = load_en;
            waddr = load_addr;
            wdata = load_data;
        end
    end

    // RULE2 working register write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            w_q <= osm_pkg::W_RESET;
        end else if (state_q == OSM_EXEC && dest_q == osm_pkg::DEST_W) begin
            w_q <= res;
        end
    end

    // RULE7 RULE6 zero flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zero_q <= 1'b0;
        end else if (state_q == OSM_EXEC) begin
            zero_q <= (res == '0);
        end
    end

    // RULE3 RULE1 carry only on shift
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            carry_q <= 1'b0;
        end else if (exec_is(state_q, op_q, osm_pkg::OSM_OP_LSL)) begin
            carry_q <= fdata[osm_pkg::MSB];
        end
    end

    // RULE7 completion pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == OSM_EXEC);
        end
    end

    // RULE7 zero after execute
    a_zero_flag: assert property (@(posedge clk) disable iff (reset) // RULE7
        state_q == OSM_EXEC |=> zero_q == (($past(res)) == 8'h00))
        else $error("zero flag wrong");
    // RULE3 carry from bit 7
    a_shift_carry: assert property (@(posedge clk) disable iff (reset) // RULE3
        (state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_LSL) |=> carry_q == $past(fdata[7]))
        else $error("carry not bit 7");
    // RULE1 carry kept on OR and move
    a_carry_kept: assert property (@(posedge clk) disable iff (reset) // RULE1
        (state_q == OSM_EXEC && op_q != osm_pkg::OSM_OP_LSL) |=> $stable(carry_q))
        else $error("carry changed");
    // RULE4 shift bit 0
    a_shift_lsb: assert property (@(posedge clk) disable iff (reset) // RULE4
        (state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_LSL && dest_q == 1'b0)
        |=> w_q[0] == 1'b0 && w_q[7:1] == $past(fdata[6:0]))
        else $error("shift result wrong");
    // RULE2 file destination keeps W
    a_dest_file: assert property (@(posedge clk) disable iff (reset) // RULE2
        (state_q == OSM_EXEC && dest_q == 1'b1) |=> $stable(w_q))
        else $error("W written on file dest");
    // RULE5 move to W
    a_move_pass: assert property (@(posedge clk) disable iff (reset) // RULE5
        (state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_MOV && dest_q == 1'b0)
        |=> w_q == $past(fdata))
        else $error("move altered data");
    // RULE6 move to self tests zero
    a_move_test: assert property (@(posedge clk) disable iff (reset) // RULE6
        (state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_MOV && dest_q == 1'b1)
        |=> zero_q == ($past(fdata) == 8'h00))
        else $error("move test zero wrong");
    // RULE7 one cycle
    a_one_cycle: assert property (@(posedge clk) disable iff (reset) // RULE7
        starts_op(op_valid, op) |=> ##1 done_q)
        else $error("not single cycle");
    // RULE1 OR result
    a_or_result: assert property (@(posedge clk) disable iff (reset) // RULE1
        (state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_IOR && dest_q == 1'b0)
        |=> w_q == ($past(w_q) | $past(fdata)))
        else $error("OR result wrong");

    // RULE1 OR zero flag
    a_or_zero: assert property (@(posedge clk) disable iff (reset) // RULE1
        exec_is(state_q, op_q, osm_pkg::OSM_OP_IOR)
        |=> zero_q == (($past(w_q) | $past(fdata)) == 8'h00))
        else $error("OR zero flag wrong");
    // RULE4 shift into file zero
    a_shift_zero: assert property (@(posedge clk) disable iff (reset) // RULE4
        (exec_is(state_q, op_q, osm_pkg::OSM_OP_LSL) && dest_q == osm_pkg::DEST_F)
        |=> zero_q == ($past(fdata[6:0]) == 7'h00))
        else $error("shift zero flag wrong");
    // RULE7 idle keeps results
    a_idle_hold: assert property (@(posedge clk) disable iff (reset) // RULE7
        state_q == OSM_IDLE |=> $stable(w_q) && $stable(zero_q) && $stable(carry_q))
        else $error("result changed while idle");
    // RULE7 done after execute
    a_done_source: assert property (@(posedge clk) disable iff (reset) // RULE7
        done_q |-> $past(state_q) == OSM_EXEC)
        else $error("done without execute");
    // RULE7 none code refused
    a_none_refused: assert property (@(posedge clk) disable iff (reset) // RULE7
        (op_valid && op == osm_pkg::OSM_OP_NONE) |=> state_q == OSM_IDLE)
        else $error("none code executed");

    // Main scenarios
    c_or:   cover property (@(posedge clk) state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_IOR);
    c_lsl:  cover property (@(posedge clk) state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_LSL
        && fdata[7]);
    c_mov:  cover property (@(posedge clk) state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_MOV
        && dest_q && fdata == 8'h00);
    c_back: cover property (@(posedge clk) state_q == OSM_EXEC && starts_op(op_valid, op));
    c_or_f: cover property (@(posedge clk) state_q == OSM_EXEC && op_q == osm_pkg::OSM_OP_IOR
        && dest_q);
endmodule // osm_core
`default_nettype wire

// ### sim/or_shift_move_byte_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none
module or_shift_move_byte_ops_tb;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             load_en = 1'b0;
    logic [6:0]       load_addr = 7'h00;
    logic [7:0]       load_data = 8'h00;
    logic             op_valid = 1'b0;
    osm_pkg::osm_op_e op = osm_pkg::OSM_OP_NONE;
    logic [6:0]       op_addr = 7'h00;
    logic             op_dest = 1'b0;
    logic [7:0]       w_q;
    logic             zero_q;
    logic             carry_q;
    logic             done_q;
    int               n_fail = 0;
    int               cmp_count = 0;
    int               cycles = 0;

    osm_core osm_core_inst (.clk(clk), .reset(reset), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .op_valid(op_valid), .op(op),
        .op_addr(op_addr), .op_dest(op_dest), .w_q(w_q), .zero_q(zero_q),
        .carry_q(carry_q), .done_q(done_q));

    always #25 clk = ~clk;

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic load(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= d;
        @(posedge clk);
        load_en <= 1'b0;
    endtask

    // Issue one instruction, wait for retirement at a settled point
    task automatic run(input osm_pkg::osm_op_e o, input logic [6:0] a, input logic d);
        int i;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        op_addr <= a;
        op_dest <= d;
        @(posedge clk);
        op_valid <= 1'b0;
        i = 0;
        while (done_q !== 1'b1 && i < 8) begin
            @(negedge clk);
            i++;
        end
        chk(8'h01, {7'h00, done_q});
        @(negedge clk);
        chk(8'h00, {7'h00, done_q});
    endtask

    task automatic flags(input logic [1:0] zc);
        chk({6'h00, zc}, {6'h00, zero_q, carry_q});
    endtask

    task automatic t_move;
        load(7'h05, 8'hA5);
        load(7'h06, 8'h00);
        run(osm_pkg::OSM_OP_MOV, 7'h05, osm_pkg::DEST_W);
        chk(8'hA5, w_q);
        flags(2'b00);
        run(osm_pkg::OSM_OP_MOV, 7'h06, osm_pkg::DEST_F);
        flags(2'b10);
        chk(8'hA5, w_q);
        run(osm_pkg::OSM_OP_MOV, 7'h06, osm_pkg::DEST_W);
        chk(8'h00, w_q);
    endtask

    task automatic t_lsl;
        load(7'h09, 8'h81);
        run(osm_pkg::OSM_OP_LSL, 7'h09, osm_pkg::DEST_W);
        chk(8'h02, w_q);
        flags(2'b01);
        load(7'h0A, 8'h80);
        run(osm_pkg::OSM_OP_LSL, 7'h0A, osm_pkg::DEST_F);
        flags(2'b11);
        chk(8'h02, w_q);
        run(osm_pkg::OSM_OP_MOV, 7'h0A, osm_pkg::DEST_W);
        chk(8'h00, w_q);
        load(7'h0B, 8'h40);
        run(osm_pkg::OSM_OP_LSL, 7'h0B, osm_pkg::DEST_W);
        chk(8'h80, w_q);
        flags(2'b00);
    endtask

    task automatic t_or;
        run(osm_pkg::OSM_OP_LSL, 7'h09, osm_pkg::DEST_W);
        load(7'h0C, 8'h50);
        run(osm_pkg::OSM_OP_IOR, 7'h0C, osm_pkg::DEST_W);
        chk(8'h52, w_q);
        flags(2'b01);
        load(7'h0D, 8'h08);
        run(osm_pkg::OSM_OP_IOR, 7'h0D, osm_pkg::DEST_F);
        chk(8'h52, w_q);
        run(osm_pkg::OSM_OP_MOV, 7'h0D, osm_pkg::DEST_W);
        chk(8'h5A, w_q);
        run(osm_pkg::OSM_OP_MOV, 7'h06, osm_pkg::DEST_W);
        run(osm_pkg::OSM_OP_IOR, 7'h06, osm_pkg::DEST_W);
        flags(2'b11);
    endtask

    task automatic t_none;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= osm_pkg::OSM_OP_NONE;
        op_addr <= 7'h05;
        @(posedge clk);
        op_valid <= 1'b0;
        repeat (3) begin
            @(negedge clk);
            chk(8'h00, {7'h00, done_q});
        end
        chk(8'h00, w_q);
    endtask

    // Two instructions on consecutive edges
    task automatic t_back;
        load(7'h0E, 8'h3C);
        load(7'h0F, 8'h00);
        @(posedge clk);
        op_valid <= 1'b1;
        op <= osm_pkg::OSM_OP_MOV;
        op_addr <= 7'h0E;
        op_dest <= osm_pkg::DEST_W;
        @(posedge clk);
        op <= osm_pkg::OSM_OP_LSL;
        op_addr <= 7'h0F;
        op_dest <= osm_pkg::DEST_F;
        @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
        chk(8'h01, {7'h00, done_q});
        chk(8'h3C, w_q);
        flags(2'b01);
        @(negedge clk);
        chk(8'h01, {7'h00, done_q});
        chk(8'h3C, w_q);
        flags(2'b10);
        run(osm_pkg::OSM_OP_MOV, 7'h0F, osm_pkg::DEST_W);
        chk(8'h00, w_q);
    endtask

    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(8'h00, w_q);
        flags(2'b00);
        t_move();
        t_lsl();
        t_or();
        t_none();
        t_back();
        end_sim();
    end
endmodule // or_shift_move_byte_ops_tb
`default_nettype wire
